// file: lmcd_decoder.sv
`timescale 1ns/1ns
`include "lmcd_params.svh"

module lmcd_decoder
  import lmcd_pkg::*;
#(
  parameter int POS_W = 16
) (
  input logic mclk,
  input logic srst,
  input lmcd_axil_req_type axiReq,
  output lmcd_axil_rsp_type axiRsp,
  input lmcd_rx_byte_type rxByte,
  input logic motorMoving,
  input logic twoPointBusy,
  input logic [POS_W-1:0] actualPosition,
  input logic thermalShutdownPin,
  output logic [POS_W-1:0] targetPosition,
  output logic targetLoad,
  output logic decelHalt,
  output logic sleepMode
);

  if (POS_W < `LMCD_SHORT_POS_W || POS_W > `LMCD_AXI_DW) begin : g_bad
    $error("lmcd_decoder position width out of range");
  end

  // frame receiver state
  lmcd_rx_state_type rxState_ff, nxt_rxState;
  logic [`LMCD_ID_W-1:0] frameId_ff, nxt_frameId;
  logic [`LMCD_MAX_DATA-1:0][`LMCD_BYTE_W-1:0] dataBuf_ff, nxt_dataBuf;
  logic [`LMCD_CNT_W-1:0] byteCnt_ff, nxt_byteCnt;
  logic [`LMCD_LEN_W-1:0] dataLen_ff, nxt_dataLen;
  logic [`LMCD_BYTE_W-1:0] csum_ff, nxt_csum;
  logic frameDone_ff, nxt_frameDone;
  logic frameGood_ff, nxt_frameGood;
  logic [`LMCD_BYTE_W:0] csumWide;

  // executor state
  lmcd_ex_state_type exState_ff, nxt_exState;
  logic [POS_W-1:0] target_ff, nxt_target;
  logic targetLoad_ff, nxt_targetLoad;
  logic sleepAfter_ff, nxt_sleepAfter;
  logic thermPrev_ff, nxt_thermPrev;
  logic thermSync;

  // register file state
  logic [`LMCD_STEP_W-1:0] stepSel_ff, nxt_stepSel;
  logic [`LMCD_NODE_W-1:0] nodeAddr_ff, nxt_nodeAddr;
  logic [`LMCD_SHORT_POS_W-1:0] securePos_ff, nxt_securePos;
  logic [`LMCD_EV_W-1:0] events_ff, nxt_events;
  logic wake_ff, nxt_wake;

  // bus slave state
  logic awHeld_ff, nxt_awHeld;
  logic wHeld_ff, nxt_wHeld;
  logic [`LMCD_AXI_AW-1:0] awAddr_ff, nxt_awAddr;
  logic [`LMCD_AXI_DW-1:0] wData_ff, nxt_wData;
  logic [`LMCD_STRB_W-1:0] wStrb_ff, nxt_wStrb;
  logic bValid_ff, nxt_bValid;
  logic [1:0] bResp_ff, nxt_bResp;
  logic rValid_ff, nxt_rValid;
  logic [`LMCD_AXI_DW-1:0] rData_ff, nxt_rData;
  logic [1:0] rResp_ff, nxt_rResp;

  // decode results
  logic cmdSleep, cmdShort, cmdStop;
  logic [`LMCD_SHORT_POS_W-1:0] shortPos;
  logic [`LMCD_EV_W-1:0] evSet;
  logic [`LMCD_EV_W-1:0] evClr;

  // on-die thermal flag is treated as asynchronous
  lmcd_sync #(.WIDTH(1)) u_therm_sync (
    .mclk(mclk),
    .srst(srst),
    .asyncIn(thermalShutdownPin),
    .syncOut(thermSync)
  );

  function automatic logic [`LMCD_LEN_W-1:0] lenFromId(input logic [`LMCD_ID_W-1:0] id);
    unique case (id[`LMCD_ID_W-1 -: 2])
      2'b00, 2'b01: lenFromId = `LMCD_LEN2;
      2'b10: lenFromId = `LMCD_LEN4;
      2'b11: lenFromId = `LMCD_LEN8;
    endcase
  endfunction

  function automatic logic [`LMCD_AXI_DW-1:0] strbMask(input logic [`LMCD_STRB_W-1:0] s);
    strbMask = '0;
    for (int b = 0; b < `LMCD_STRB_W; b++) begin
      strbMask[b*`LMCD_BYTE_W +: `LMCD_BYTE_W] = {`LMCD_BYTE_W{s[b]}};
    end
  endfunction

  // receiver: identifier byte always restarts, so a torn frame is dropped
  always_comb begin
    nxt_rxState = rxState_ff;
    nxt_frameId = frameId_ff;
    nxt_dataBuf = dataBuf_ff;
    nxt_byteCnt = byteCnt_ff;
    nxt_dataLen = dataLen_ff;
    nxt_csum = csum_ff;
    nxt_frameDone = 1'b0;
    nxt_frameGood = 1'b0;
    csumWide = {1'b0, csum_ff} + {1'b0, rxByte.data};
    if (rxByte.valid && rxByte.isId) begin
      nxt_rxState = RX_DATA;
      nxt_frameId = rxByte.data[`LMCD_ID_W-1:0];
      nxt_dataLen = lenFromId(rxByte.data[`LMCD_ID_W-1:0]);
      nxt_byteCnt = '0;
      nxt_csum = '0;
    end else if (rxByte.valid) begin
      unique case (rxState_ff)
        RX_IDLE: begin
          nxt_rxState = RX_IDLE;
        end
        RX_DATA: begin
          nxt_dataBuf[byteCnt_ff] = rxByte.data;
          nxt_csum = csumWide[`LMCD_BYTE_W-1:0] + {{(`LMCD_BYTE_W-1){1'b0}}, csumWide[`LMCD_BYTE_W]};
          nxt_byteCnt = byteCnt_ff + 1'b1;
          if (byteCnt_ff == `LMCD_CNT_W'(dataLen_ff - 1'b1)) begin
            nxt_rxState = RX_CSUM;
          end
        end
        RX_CSUM: begin
          nxt_frameDone = 1'b1;
          nxt_frameGood = (rxByte.data == ~csum_ff);
          nxt_rxState = RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rxState_ff <= RX_IDLE;
      frameId_ff <= '0;
      dataBuf_ff <= '0;
      byteCnt_ff <= '0;
      dataLen_ff <= `LMCD_LEN2;
      csum_ff <= '0;
      frameDone_ff <= 1'b0;
      frameGood_ff <= 1'b0;
    end else begin
      rxState_ff <= nxt_rxState;
      frameId_ff <= nxt_frameId;
      dataBuf_ff <= nxt_dataBuf;
      byteCnt_ff <= nxt_byteCnt;
      dataLen_ff <= nxt_dataLen;
      csum_ff <= nxt_csum;
      frameDone_ff <= nxt_frameDone;
      frameGood_ff <= nxt_frameGood;
    end
  end

  // command decode of a completed, checksum-clean frame
  always_comb begin
    cmdSleep = 1'b0;
    cmdShort = 1'b0;
    cmdStop = 1'b0;
    shortPos = '0;
    if (frameDone_ff && frameGood_ff) begin
      if (frameId_ff == `LMCD_MREQ_ID) begin
        cmdSleep = (dataBuf_ff[0] == `LMCD_SLEEP_FIRST);
        for (int i = 1; i < `LMCD_MAX_DATA; i++) begin
          if (dataBuf_ff[i] != `LMCD_SLEEP_FILL) begin
            cmdSleep = 1'b0;
          end
        end
      end else if (frameId_ff[`LMCD_ID_W-1 -: 2] == `LMCD_SHORT_LEN_CODE) begin
        // lowest slot wins if the master repeats an address
        for (int s = `LMCD_SHORT_SLOTS - 1; s >= 0; s--) begin
          if (dataBuf_ff[2*s][`LMCD_SHORT_MARK_BIT] &&
              dataBuf_ff[2*s][`LMCD_SHORT_ADDR_W-1:0] ==
              nodeAddr_ff[`LMCD_SHORT_ADDR_W-1:0]) begin
            cmdShort = (stepSel_ff == `LMCD_HALF_STEP);
            shortPos = {dataBuf_ff[2*s][`LMCD_SHORT_POS_HI:`LMCD_SHORT_POS_LO],
                        dataBuf_ff[2*s+1]};
          end
        end
      end else if (dataBuf_ff[0] == {1'b1, `LMCD_STOP_CODE}) begin
        cmdStop = !dataBuf_ff[1][`LMCD_BROAD_BIT] ||
                  dataBuf_ff[1][`LMCD_NODE_W-1:0] == nodeAddr_ff;
      end
    end
  end

  // executor: moves, stops and the sleep hand-off to the ramp generator
  always_comb begin
    nxt_exState = exState_ff;
    nxt_target = target_ff;
    nxt_targetLoad = 1'b0;
    nxt_sleepAfter = sleepAfter_ff;
    nxt_thermPrev = thermSync;
    evSet = {cmdSleep, cmdStop, cmdShort, frameDone_ff & ~frameGood_ff};
    unique case (exState_ff)
      EX_RUN: begin
        if (cmdSleep) begin
          if (!motorMoving) begin
            nxt_exState = EX_SLEEP;
          end else if (securePos_ff != `LMCD_SECURE_POSITION_DISABLED) begin
            nxt_target = POS_W'($signed(securePos_ff));
            nxt_targetLoad = 1'b1;
            nxt_exState = EX_SEC_WAIT;
          end else begin
            nxt_sleepAfter = 1'b1;
            nxt_exState = EX_STOP;
          end
        end else if (cmdShort) begin
          nxt_target = POS_W'($signed(shortPos));
          nxt_targetLoad = 1'b1;
        end else if (motorMoving && ((cmdStop && !twoPointBusy) ||
                                     (thermSync && !thermPrev_ff))) begin
          nxt_sleepAfter = 1'b0;
          nxt_exState = EX_STOP;
        end
      end
      EX_STOP: begin
        if (cmdSleep) begin
          nxt_sleepAfter = 1'b1;
        end
        if (!motorMoving) begin
          nxt_target = actualPosition;
          nxt_targetLoad = 1'b1;
          nxt_exState = (sleepAfter_ff || cmdSleep) ? EX_SLEEP : EX_RUN;
        end
      end
      EX_SEC_WAIT: begin
        // the ramp runs on to the secure point; sleep only once it rests
        if (!motorMoving) begin
          nxt_exState = EX_SLEEP;
        end else if ((cmdStop && !twoPointBusy) ||
                     (thermSync && !thermPrev_ff)) begin
          nxt_sleepAfter = 1'b1;
          nxt_exState = EX_STOP;
        end
      end
      EX_SLEEP: begin
        nxt_sleepAfter = 1'b0;
        if (wake_ff) begin
          nxt_exState = EX_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      exState_ff <= EX_RUN;
      target_ff <= '0;
      targetLoad_ff <= 1'b0;
      sleepAfter_ff <= 1'b0;
      thermPrev_ff <= 1'b0;
    end else begin
      exState_ff <= nxt_exState;
      target_ff <= nxt_target;
      targetLoad_ff <= nxt_targetLoad;
      sleepAfter_ff <= nxt_sleepAfter;
      thermPrev_ff <= nxt_thermPrev;
    end
  end

  // bus slave: address and data taken in either order, one write at a time
  always_comb begin
    logic [`LMCD_AXI_DW-1:0] mask;
    logic [`LMCD_AXI_DW-1:0] merged;
    logic [`LMCD_AXI_AW-1:0] wAddr;
    logic [`LMCD_AXI_AW-1:0] rAddr;
    mask = strbMask(wStrb_ff);
    merged = '0;
    wAddr = {awAddr_ff[`LMCD_AXI_AW-1:`LMCD_WORD_LSB], `LMCD_WORD_LSB'(0)};
    rAddr = {axiReq.araddr[`LMCD_AXI_AW-1:`LMCD_WORD_LSB], `LMCD_WORD_LSB'(0)};
    nxt_awHeld = awHeld_ff;
    nxt_wHeld = wHeld_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wData = wData_ff;
    nxt_wStrb = wStrb_ff;
    nxt_bValid = bValid_ff;
    nxt_bResp = bResp_ff;
    nxt_rValid = rValid_ff;
    nxt_rData = rData_ff;
    nxt_rResp = rResp_ff;
    nxt_stepSel = stepSel_ff;
    nxt_nodeAddr = nodeAddr_ff;
    nxt_securePos = securePos_ff;
    nxt_wake = 1'b0;
    evClr = '0;
    if (axiReq.awvalid && axiRsp.awready) begin
      nxt_awHeld = 1'b1;
      nxt_awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && axiRsp.wready) begin
      nxt_wHeld = 1'b1;
      nxt_wData = axiReq.wdata;
      nxt_wStrb = axiReq.wstrb;
    end
    if (awHeld_ff && wHeld_ff && !bValid_ff) begin
      nxt_awHeld = 1'b0;
      nxt_wHeld = 1'b0;
      nxt_bValid = 1'b1;
      nxt_bResp = `LMCD_RESP_OKAY;
      unique case (wAddr)
        `LMCD_OFF_CTRL: begin
          merged = ({`LMCD_AXI_DW'(stepSel_ff)} & ~mask) | (wData_ff & mask);
          nxt_stepSel = merged[`LMCD_STEP_W-1:0];
          nxt_wake = merged[`LMCD_WAKE_BIT];
        end
        `LMCD_OFF_ADDR: begin
          merged = ({`LMCD_AXI_DW'(nodeAddr_ff)} & ~mask) | (wData_ff & mask);
          nxt_nodeAddr = merged[`LMCD_NODE_W-1:0];
        end
        `LMCD_OFF_SECURE_POSITION: begin
          merged = ({`LMCD_AXI_DW'(securePos_ff)} & ~mask) | (wData_ff & mask);
          nxt_securePos = merged[`LMCD_SHORT_POS_W-1:0];
        end
        `LMCD_OFF_EVENTS: begin
          merged = wData_ff & mask;
          evClr = merged[`LMCD_EV_W-1:0];
        end
        `LMCD_OFF_STATUS, `LMCD_OFF_TARGET: begin
          merged = '0;
        end
        default: begin
          nxt_bResp = `LMCD_RESP_SLVERR;
        end
      endcase
    end
    if (bValid_ff && axiReq.bready) begin
      nxt_bValid = 1'b0;
    end
    if (axiReq.arvalid && axiRsp.arready) begin
      nxt_rValid = 1'b1;
      nxt_rResp = `LMCD_RESP_OKAY;
      unique case (rAddr)
        `LMCD_OFF_CTRL: nxt_rData = `LMCD_AXI_DW'(stepSel_ff);
        `LMCD_OFF_ADDR: nxt_rData = `LMCD_AXI_DW'(nodeAddr_ff);
        `LMCD_OFF_SECURE_POSITION: nxt_rData = `LMCD_AXI_DW'(securePos_ff);
        `LMCD_OFF_STATUS: nxt_rData = `LMCD_AXI_DW'({thermSync, exState_ff == EX_SEC_WAIT,
                                                   exState_ff == EX_STOP,
                                                   exState_ff == EX_SLEEP});
        `LMCD_OFF_TARGET: nxt_rData = `LMCD_AXI_DW'(target_ff);
        `LMCD_OFF_EVENTS: nxt_rData = `LMCD_AXI_DW'(events_ff);
        default: begin
          nxt_rData = '0;
          nxt_rResp = `LMCD_RESP_SLVERR;
        end
      endcase
    end else if (rValid_ff && axiReq.rready) begin
      nxt_rValid = 1'b0;
    end
    // a new event beats a clear in the same cycle
    nxt_events = (events_ff & ~evClr) | evSet;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= '0;
      wStrb_ff <= '0;
      bValid_ff <= 1'b0;
      bResp_ff <= `LMCD_RESP_OKAY;
      rValid_ff <= 1'b0;
      rData_ff <= '0;
      rResp_ff <= `LMCD_RESP_OKAY;
      stepSel_ff <= `LMCD_STEP_RST;
      nodeAddr_ff <= `LMCD_NODE_RST;
      securePos_ff <= `LMCD_SECURE_POSITION_DISABLED;
      events_ff <= `LMCD_EV_RST;
      wake_ff <= 1'b0;
    end else begin
      awHeld_ff <= nxt_awHeld;
      wHeld_ff <= nxt_wHeld;
      awAddr_ff <= nxt_awAddr;
      wData_ff <= nxt_wData;
      wStrb_ff <= nxt_wStrb;
      bValid_ff <= nxt_bValid;
      bResp_ff <= nxt_bResp;
      rValid_ff <= nxt_rValid;
      rData_ff <= nxt_rData;
      rResp_ff <= nxt_rResp;
      stepSel_ff <= nxt_stepSel;
      nodeAddr_ff <= nxt_nodeAddr;
      securePos_ff <= nxt_securePos;
      events_ff <= nxt_events;
      wake_ff <= nxt_wake;
    end
  end

  always_comb begin
    axiRsp.awready = !awHeld_ff && !bValid_ff;
    axiRsp.wready = !wHeld_ff && !bValid_ff;
    axiRsp.bvalid = bValid_ff;
    axiRsp.bresp = bResp_ff;
    axiRsp.arready = !rValid_ff;
    axiRsp.rvalid = rValid_ff;
    axiRsp.rdata = rData_ff;
    axiRsp.rresp = rResp_ff;
  end

  assign targetPosition = target_ff;
  assign targetLoad = targetLoad_ff;
  assign decelHalt = (exState_ff == EX_STOP);
  assign sleepMode = (exState_ff == EX_SLEEP);

endmodule

// file: lmcd_params.svh
`ifndef LMCD_PARAMS_SVH
`define LMCD_PARAMS_SVH

// bus geometry
`define LMCD_AXI_AW 8
`define LMCD_AXI_DW 32
`define LMCD_STRB_W 4
`define LMCD_BYTE_W 8
`define LMCD_WORD_LSB 2

// register byte offsets
`define LMCD_OFF_CTRL 8'h00
`define LMCD_OFF_ADDR 8'h04
`define LMCD_OFF_SECURE_POSITION 8'h08
`define LMCD_OFF_STATUS 8'h0c
`define LMCD_OFF_TARGET 8'h10
`define LMCD_OFF_EVENTS 8'h14

// register fields and reset values
`define LMCD_WAKE_BIT 8
`define LMCD_STEP_W 2
`define LMCD_NODE_W 7
`define LMCD_SHORT_ADDR_W 4
`define LMCD_STEP_RST 2'b00
`define LMCD_NODE_RST 7'h00
`define LMCD_SECURE_POSITION_DISABLED 11'h400
`define LMCD_EV_W 4
`define LMCD_EV_RST 4'h0
`define LMCD_RESP_OKAY 2'b00
`define LMCD_RESP_SLVERR 2'b10

// frame layout and command codes
`define LMCD_ID_W 6
`define LMCD_MAX_DATA 8
`define LMCD_CNT_W 3
`define LMCD_LEN_W 4
`define LMCD_LEN2 4'd2
`define LMCD_LEN4 4'd4
`define LMCD_LEN8 4'd8
`define LMCD_MREQ_ID 6'h3c
`define LMCD_SLEEP_FIRST 8'h00
`define LMCD_SLEEP_FILL 8'hff
`define LMCD_STOP_CODE 7'h0f
`define LMCD_CMD_FLAG_BIT 7
`define LMCD_BROAD_BIT 7
`define LMCD_SHORT_LEN_CODE 2'b11
`define LMCD_HALF_STEP 2'b00
`define LMCD_SHORT_SLOTS 4
`define LMCD_SHORT_MARK_BIT 4
`define LMCD_SHORT_POS_W 11
`define LMCD_SHORT_POS_HI 7
`define LMCD_SHORT_POS_LO 5

`endif

// file: lmcd_pkg.sv
`include "lmcd_params.svh"

package lmcd_pkg;

  typedef struct packed {
    logic awvalid;
    logic [`LMCD_AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [`LMCD_AXI_DW-1:0] wdata;
    logic [`LMCD_STRB_W-1:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`LMCD_AXI_AW-1:0] araddr;
    logic rready;
  } lmcd_axil_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [`LMCD_AXI_DW-1:0] rdata;
    logic [1:0] rresp;
  } lmcd_axil_rsp_type;

  typedef struct packed {
    logic valid;
    logic isId;
    logic [`LMCD_BYTE_W-1:0] data;
  } lmcd_rx_byte_type;

  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_CSUM} lmcd_rx_state_type;

  typedef enum logic [1:0] {EX_RUN, EX_STOP, EX_SEC_WAIT, EX_SLEEP} lmcd_ex_state_type;

endpackage

// file: lmcd_sync.sv
`timescale 1ns/1ns

module lmcd_sync #(
  parameter int WIDTH = 1
) (
  input logic mclk,
  input logic srst,
  input logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] nxt_out;
  logic [WIDTH-1:0] agree;

  if (WIDTH < 1) begin : g_bad
    $error("lmcd_sync width must be at least one");
  end

  // only stages two and three are compared, stage one feeds stage two alone
  always_comb begin
    agree = ~(stage2_ff ^ stage3_ff);
    nxt_out = (out_ff & ~agree) | (stage3_ff & agree);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
      out_ff <= '0;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      out_ff <= nxt_out;
    end
  end

  assign syncOut = out_ff;

endmodule

// file: lmcd_decoder_sva.sv
`timescale 1ns/1ns
module lmcd_decoder_sva
  import lmcd_pkg::*;
#(
  parameter int POS_W = 16
) (
  input logic mclk,
  input logic srst,
  input lmcd_axil_req_type axiReq,
  input lmcd_axil_rsp_type axiRsp,
  input lmcd_rx_byte_type rxByte,
  input logic motorMoving,
  input logic twoPointBusy,
  input logic [POS_W-1:0] actualPosition,
  input logic thermalShutdownPin,
  input logic [POS_W-1:0] targetPosition,
  input logic targetLoad,
  input logic decelHalt,
  input logic sleepMode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_halt_ends: assert property (decelHalt && !motorMoving |=> targetLoad && !decelHalt
    && targetPosition == $past(actualPosition)) else $error("stop end wrong");
  a_halt_holds: assert property (decelHalt && motorMoving |=> decelHalt)
    else $error("stop dropped early");
  // past reset guard: the reset clear is not a load
  a_load_marks: assert property (!$stable(targetPosition) && !$past(srst) |-> targetLoad)
    else $error("target changed silently");
  a_stop_moving: assert property ($rose(decelHalt) |-> $past(motorMoving))
    else $error("stop while still");
  a_sleep_clean: assert property (sleepMode |-> !decelHalt)
    else $error("asleep while stopping");
  a_sleep_still: assert property ($rose(sleepMode) |-> !$past(motorMoving))
    else $error("asleep while moving");
  a_thermal_stop: assert property ($rose(thermalShutdownPin) && motorMoving && !sleepMode
    |-> ##[1:8] (decelHalt || !motorMoving)) else $error("no thermal stop");
  a_bresp_hold: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid
    && $stable(axiRsp.bresp)) else $error("write answer dropped");
  a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read unanswered");
endmodule

bind lmcd_decoder lmcd_decoder_sva #(.POS_W(POS_W)) uSva (
  .mclk(mclk), .srst(srst), .axiReq(axiReq), .axiRsp(axiRsp), .rxByte(rxByte),
  .motorMoving(motorMoving), .twoPointBusy(twoPointBusy), .actualPosition(actualPosition),
  .thermalShutdownPin(thermalShutdownPin), .targetPosition(targetPosition),
  .targetLoad(targetLoad), .decelHalt(decelHalt), .sleepMode(sleepMode));

// file: lmcd_lin_master.sv
`timescale 1ns/1ns
module lmcd_lin_master
  import lmcd_pkg::*;
(
  input logic mclk,
  output lmcd_rx_byte_type rxByte
);
  initial rxByte = '0;
  // bytes back to back, the tightest spacing the receiver allows
  task automatic send(input logic [5:0] id, input logic [63:0] bytes, input int n,
    input logic bad);
    logic [8:0] s;
    logic [7:0] sum;
    sum = 8'h00;
    @(posedge mclk);
    rxByte <= {1'b1, 1'b1, 2'b00, id};
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      rxByte <= {1'b1, 1'b0, bytes[63-8*i -: 8]};
      s = sum + bytes[63-8*i -: 8];
      sum = s[7:0] + 8'(s[8]);
    end
    @(posedge mclk);
    rxByte <= {1'b1, 1'b0, ~sum ^ {7'h00, bad}};
    @(posedge mclk);
    // idle line must not keep showing the checksum
    rxByte <= {1'b0, 1'b0, sum};
  endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ns
`include "lmcd_params.svh"
module testbench
  import lmcd_pkg::*;
;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  lmcd_axil_req_type axiReq = '0;
  lmcd_axil_rsp_type axiRsp;
  lmcd_rx_byte_type rxByte;
  logic motorMoving = 1'b0;
  logic twoPointBusy = 1'b0;
  logic [15:0] actualPosition = 16'h0000;
  logic thermalShutdownPin = 1'b0;
  logic [15:0] targetPosition;
  logic targetLoad;
  logic decelHalt;
  logic sleepMode;
  int bad_count = 0;
  int samples_checked = 0;
  int loads = 0;

  initial forever #5 mclk = ~mclk;

  lmcd_decoder #(.POS_W(16)) DUT (.mclk(mclk), .srst(srst), .axiReq(axiReq),
    .axiRsp(axiRsp), .rxByte(rxByte), .motorMoving(motorMoving),
    .twoPointBusy(twoPointBusy), .actualPosition(actualPosition),
    .thermalShutdownPin(thermalShutdownPin), .targetPosition(targetPosition),
    .targetLoad(targetLoad), .decelHalt(decelHalt), .sleepMode(sleepMode));
  lmcd_lin_master linMaster (.mclk(mclk), .rxByte(rxByte));

  always @(posedge mclk) if (targetLoad === 1'b1) loads++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hf;
    axiReq.bready <= 1'b1;
    // no cycle count assumed: only the watchdog ends a stuck wait
    while (!done) begin
      @(posedge mclk);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid) begin
        axiReq.bready <= 1'b0;
        check(32'(axiRsp.bresp), 32'(`LMCD_RESP_OKAY));
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid) begin
        axiReq.rready <= 1'b0;
        d = axiRsp.rdata;
        r = axiRsp.rresp;
        done = 1'b1;
      end
    end
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(`LMCD_OFF_SECURE_POSITION, d, r);
    check(d, 32'h0000_0400);
    rd(8'h18, d, r);
    check(32'(r), 32'(`LMCD_RESP_SLVERR));
    wr(`LMCD_OFF_ADDR, 32'h25);
    rd(`LMCD_OFF_ADDR, d, r);
    check(d, 32'h25);
    $display("regs done");
  endtask

  task automatic t_short();
    int l;
    logic [31:0] d;
    logic [1:0] r;
    l = loads;
    linMaster.send(6'h31, 64'h1300_b5a3_3511_1300, 8, 1'b0);
    cyc(4);
    check(32'(targetPosition), 32'h0000_fda3);
    linMaster.send(6'h31, 64'h1301_b5a3_3511_1300, 8, 1'b1);
    wr(`LMCD_OFF_CTRL, 32'h1);
    linMaster.send(6'h31, 64'h1300_b5a3_3511_1300, 8, 1'b0);
    wr(`LMCD_OFF_CTRL, 32'h0);
    linMaster.send(6'h31, 64'h1300_b4a3_3411_1300, 8, 1'b0);
    linMaster.send(6'h21, 64'hb5a3_3511_0000_0000, 4, 1'b0);
    cyc(4);
    check(32'(loads - l), 32'h1);
    linMaster.send(6'h3f, 64'h1300_1300_1300_7505, 8, 1'b0);
    cyc(4);
    check(32'(targetPosition), 32'h0000_0305);
    rd(`LMCD_OFF_EVENTS, d, r);
    check(d, 32'h3);
    wr(`LMCD_OFF_EVENTS, 32'h1);
    rd(`LMCD_OFF_EVENTS, d, r);
    check(d, 32'h2);
    $display("short done");
  endtask

  task automatic t_stop();
    // ids with bit 5 clear: the stop is a two byte general frame
    logic [5:0] ids [4] = '{6'h05, 6'h0a, 6'h1f, 6'h05};
    logic [7:0] b2 [4] = '{8'h00, 8'ha4, 8'ha5, 8'h00};
    logic [3:0] busy = 4'b1000;
    logic [3:0] hit = 4'b0101;
    for (int i = 0; i < 4; i++) begin
      motorMoving <= 1'b1;
      twoPointBusy <= busy[i];
      linMaster.send(ids[i], {8'h8f, b2[i], 48'h0}, 2, 1'b0);
      cyc(4);
      check(32'(decelHalt), 32'(hit[i]));
      actualPosition <= 16'h0100 + 16'(i);
      motorMoving <= 1'b0;
      cyc(3);
      if (hit[i]) check(32'(targetPosition), 32'h100 + i);
      check(32'(decelHalt), 32'h0);
    end
    twoPointBusy <= 1'b0;
    $display("stop done");
  endtask

  task automatic t_thermal();
    motorMoving <= 1'b1;
    thermalShutdownPin <= 1'b1;
    cyc(8);
    check(32'(decelHalt), 32'h1);
    actualPosition <= 16'h0777;
    motorMoving <= 1'b0;
    cyc(3);
    check(32'(targetPosition), 32'h0777);
    thermalShutdownPin <= 1'b0;
    $display("thermal done");
  endtask

  task automatic t_sleep();
    logic [63:0] slp = 64'h00ff_ffff_ffff_ffff;
    logic [31:0] d;
    logic [1:0] r;
    motorMoving <= 1'b1;
    linMaster.send(6'h3c, slp, 8, 1'b0);
    cyc(4);
    check(32'(decelHalt), 32'h1);
    motorMoving <= 1'b0;
    cyc(3);
    check(32'({sleepMode, decelHalt}), 32'h2);
    wr(`LMCD_OFF_CTRL, 32'h100);
    wr(`LMCD_OFF_SECURE_POSITION, 32'h655);
    motorMoving <= 1'b1;
    linMaster.send(6'h3c, slp, 8, 1'b0);
    cyc(4);
    check(32'({sleepMode, targetPosition}), 32'h0000_fe55);
    rd(`LMCD_OFF_STATUS, d, r);
    check(d, 32'h4);
    rd(`LMCD_OFF_TARGET, d, r);
    check(d, 32'h0000_fe55);
    motorMoving <= 1'b0;
    cyc(3);
    check(32'(sleepMode), 32'h1);
    wr(`LMCD_OFF_CTRL, 32'h100);
    linMaster.send(6'h3c, 64'h01ff_ffff_ffff_ffff, 8, 1'b0);
    cyc(4);
    check(32'(sleepMode), 32'h0);
    linMaster.send(6'h3c, slp, 8, 1'b0);
    cyc(4);
    check(32'(sleepMode), 32'h1);
    $display("sleep done");
  endtask

  initial begin
    #200000;
    bad_count++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    t_regs();
    t_short();
    t_stop();
    t_thermal();
    t_sleep();
    close_out();
  end
endmodule
